// file: hw/tuf_pkg.sv
// Package: constants shared by the touch controller serial command framer.
// Behaviour
// - Link runs 38400 baud, eight data bits, no parity, one stop bit.
// - Every command except wakeup A7 gets one reply byte, normally CA, plus result bytes; B8 to BE answer only after their argument byte.
// - Command bytes have bit 7 set; argument bytes have bit 7 clear.
// - Packets are five bytes with pressure enabled, four bytes otherwise.
// - Header is 1,0,0,L,0000 where L marks a five byte packet.
// - Second packet byte bit 6 is touch state: one touching, zero liftoff.
// - X and Y low bits in byte 2, high bits in bytes 3 and 4.
// - Fifth byte holds 7-bit pressure, sent only while pressure is enabled.
// - Reads B0 to B4 answer CA, except version read B2 answering C7.
// - Calibration count read B3 returns 00, 02, 05 or 0D after acknowledge.
// - Focus command B8 takes 00 to 3F, acknowledged and echoed.
// - Samples command BA takes 01,02,04,08,10 or 20, acknowledged and echoed.
// - Mode command BB takes 01, 02 or 04, acknowledged and echoed.
// - Max delta command BC takes 00 to 3F, acknowledged and echoed.
// - Toggle commands A0,A2,A3,A4,A5 invert their flag, reply CA and new state.
// - Minimum pressure is doubled internally; default value is 40.
// - Clock speed byte is 0 for slow oscillator, 1 for fast.
package tuf_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD = 38400;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam logic [10:0] BIT_LAST = 11'(BIT_CYC - 1);
	localparam logic [10:0] HALF_LAST = 11'(BIT_CYC / 2 - 1);
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam logic [7:0] CMD_FILTER = 8'ha0;
	localparam logic [7:0] CMD_PWRDN = 8'ha2;
	localparam logic [7:0] CMD_ECHO = 8'ha3;
	localparam logic [7:0] CMD_PRESS = 8'ha4;
	localparam logic [7:0] CMD_CALCHK = 8'ha5;
	localparam logic [7:0] CMD_WAKE = 8'ha7;
	localparam logic [7:0] CMD_SHUT = 8'ha8;
	localparam logic [7:0] CMD_SRESET = 8'haf;
	localparam logic [7:0] CMD_CLKRD = 8'hb0;
	localparam logic [7:0] CMD_PARAMS = 8'hb1;
	localparam logic [7:0] CMD_VERSION = 8'hb2;
	localparam logic [7:0] CMD_CALCNT = 8'hb3;
	localparam logic [7:0] CMD_CALPTS = 8'hb4;
	localparam logic [7:0] CMD_FOCUS = 8'hb8;
	localparam logic [7:0] CMD_SAMPLES = 8'hba;
	localparam logic [7:0] CMD_MODE = 8'hbb;
	localparam logic [7:0] CMD_DELTA = 8'hbc;
	localparam logic [7:0] CMD_CALSET = 8'hbd;
	localparam logic [7:0] CMD_MINP = 8'hbe;
	localparam logic [7:0] RPL_ACK = 8'hca;
	localparam logic [7:0] RPL_VERSION = 8'hc7;
	localparam logic [7:0] RPL_ERROR = 8'hc8;
	localparam logic [7:0] RPL_TEST_OK = 8'hcb;
	localparam logic [7:0] RPL_TEST_BAD = 8'hcc;
	localparam logic [7:0] RPL_RESEND = 8'hce;
	localparam logic [7:0] RPL_TIMEOUT = 8'hcf;
	localparam logic [5:0] DEF_FOCUS = 6'h04;
	localparam logic [5:0] DEF_SAMPLES = 6'h08;
	localparam logic [2:0] DEF_MODE = 3'h1;
	localparam logic [5:0] DEF_DELTA = 6'h08;
	localparam logic [6:0] DEF_MINP = 7'h28;
	localparam logic [3:0] PKT_LEN_SHORT = 4'h4;
	localparam logic [3:0] PKT_LEN_LONG = 4'h5;
	localparam logic [3:0] PARAMS_LEN = 4'hd;
endpackage

// file: hw/tuf_stream_if.sv
// Interface: valid/ready byte stream between the framer and its buffer.
`timescale 1ns/1ps
`default_nettype none
interface tuf_stream_if #(parameter int W = 8) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport prod (output valid, output data, input ready);
	modport cons (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hw/tuf_buf2.sv
// Module: two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tuf_buf2 #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	tuf_stream_if.cons in_s,
	tuf_stream_if.prod out_s
);
	typedef struct packed {
		logic [1:0][W-1:0] ent;
		logic [1:0] cnt;
	} tuf_buf_s;
	tuf_buf_s st_ff;
	tuf_buf_s nxt_st;
	logic push;
	logic pop;
	assign in_s.ready = (st_ff.cnt != 2'h2);
	assign out_s.valid = (st_ff.cnt != 2'h0);
	assign out_s.data = st_ff.ent[0];
	always_comb
	begin
		nxt_st = st_ff;
		push = in_s.valid && in_s.ready;
		pop = out_s.valid && out_s.ready;
		if (pop)
		begin
			nxt_st.ent[0] = st_ff.ent[1];
		end
		if (push)
		begin
			nxt_st.ent[(!pop && st_ff.cnt == 2'h1) ? 1 : 0] = in_s.data;
		end
		case ({push, pop})
			2'b10: nxt_st.cnt = st_ff.cnt + 2'h1;
			2'b01: nxt_st.cnt = st_ff.cnt - 2'h1;
			default: nxt_st.cnt = st_ff.cnt;
		endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule // tuf_buf2
`default_nettype wire

// file: hw/tuf_framer.sv
// Module: serial command interpreter and touch packet framer, top level.
`timescale 1ns/1ps
`default_nettype none
module tuf_framer #(
	parameter logic [7:0] VER_YEAR = 8'h01,
	parameter logic [7:0] VER_MONTH = 8'h01,
	parameter logic [7:0] VER_DAY = 8'h01
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic uart_rx_i,
	output logic uart_tx_o,
	input wire logic clk_fast_i,
	input wire logic selftest_ok_i,
	input wire logic timeout_i,
	input wire logic resend_i,
	input wire logic rpt_valid_i,
	output logic rpt_ready_o,
	input wire logic rpt_touch_i,
	input wire logic [9:0] rpt_x_i,
	input wire logic [9:0] rpt_y_i,
	input wire logic [6:0] rpt_z_i,
	output logic [5:0] focus_o,
	output logic [5:0] samples_o,
	output logic [2:0] mode_o,
	output logic [5:0] max_delta_o,
	output logic [7:0] min_press_o,
	output logic [3:0] cal_count_o,
	output logic filter_en_o,
	output logic pwrdn_en_o,
	output logic echo_en_o,
	output logic press_en_o,
	output logic calchk_en_o,
	output logic wake_o,
	output logic shutdown_o,
	output logic soft_reset_o
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tuf_rx_e;
	typedef struct packed {
		logic [2:0] rx_sync;
		logic rx_lvl;
		tuf_rx_e rx_st;
		logic [10:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] hold;
		logic have;
		logic ovr;
		logic [2:0] clk_sync;
		logic clk_fast;
		logic tx_busy;
		logic [10:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic [7:0] pend;
		logic wait_arg;
		logic [5:0] focus;
		logic [5:0] samples;
		logic [2:0] mode;
		logic [5:0] delta;
		logic [6:0] minp;
		logic [7:0] calsel;
		logic [3:0] calcnt;
		logic filt;
		logic pwr;
		logic echo;
		logic press;
		logic calchk;
		logic to_pend;
		logic rs_pend;
		logic wake;
		logic shut;
		logic sreset;
		logic [12:0][7:0] rbuf;
		logic [3:0] len;
	} tuf_st_s;
	localparam tuf_st_s ST_RST = '{
		rx_sync: 3'h7, rx_lvl: 1'b1, rx_st: RX_IDLE, tx_sh: 10'h3ff,
		focus: tuf_pkg::DEF_FOCUS, samples: tuf_pkg::DEF_SAMPLES,
		mode: tuf_pkg::DEF_MODE, delta: tuf_pkg::DEF_DELTA,
		minp: tuf_pkg::DEF_MINP, default: '0};
	tuf_st_s st_ff;
	tuf_st_s nxt_st;
	logic take;
	logic pkt_take;
	logic [7:0] b;
	tuf_stream_if #(.W(8)) push_s ();
	tuf_stream_if #(.W(8)) pop_s ();
	tuf_buf2 #(.W(8)) u_buf (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.in_s(push_s.cons),
		.out_s(pop_s.prod)
	);
	// A stalled transmitter holds the reply queue, which in turn holds off new reports.
	assign take = st_ff.have && (st_ff.len == 4'h0);
	assign rpt_ready_o = (st_ff.len == 4'h0) && !st_ff.have && !st_ff.ovr
		&& !st_ff.to_pend && !st_ff.rs_pend;
	assign pkt_take = rpt_valid_i && rpt_ready_o;
	assign b = st_ff.hold;
	assign push_s.valid = (st_ff.len != 4'h0);
	assign push_s.data = st_ff.rbuf[0];
	assign pop_s.ready = !st_ff.tx_busy;
	assign uart_tx_o = st_ff.tx_sh[0];
	assign focus_o = st_ff.focus;
	assign samples_o = st_ff.samples;
	assign mode_o = st_ff.mode;
	assign max_delta_o = st_ff.delta;
	assign min_press_o = {st_ff.minp, 1'b0};
	assign cal_count_o = st_ff.calcnt;
	assign filter_en_o = st_ff.filt;
	assign pwrdn_en_o = st_ff.pwr;
	assign echo_en_o = st_ff.echo;
	assign press_en_o = st_ff.press;
	assign calchk_en_o = st_ff.calchk;
	assign wake_o = st_ff.wake;
	assign shutdown_o = st_ff.shut;
	assign soft_reset_o = st_ff.sreset;
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.wake = 1'b0;
		nxt_st.shut = 1'b0;
		nxt_st.sreset = 1'b0;
		// A pin level counts only once the second and third stages agree.
		nxt_st.rx_sync = {st_ff.rx_sync[1:0], uart_rx_i};
		if (st_ff.rx_sync[1] == st_ff.rx_sync[2])
			nxt_st.rx_lvl = st_ff.rx_sync[2];
		nxt_st.clk_sync = {st_ff.clk_sync[1:0], clk_fast_i};
		if (st_ff.clk_sync[1] == st_ff.clk_sync[2])
			nxt_st.clk_fast = st_ff.clk_sync[2];
		if (timeout_i)
			nxt_st.to_pend = 1'b1;
		if (resend_i)
			nxt_st.rs_pend = 1'b1;
		// Reply queue drains one byte per accepted push.
		if (push_s.valid && push_s.ready)
		begin
			nxt_st.rbuf = {8'h00, st_ff.rbuf[12:1]};
			nxt_st.len = st_ff.len - 4'h1;
		end
		if (take)
		begin
			nxt_st.have = 1'b0;
			nxt_st.rbuf = '0;
			nxt_st.rbuf[0] = tuf_pkg::RPL_ACK;
			nxt_st.len = 4'h2;
			if (b[7])
			begin
				nxt_st.wait_arg = 1'b0;
				case (b)
					tuf_pkg::CMD_FILTER:
					begin
						nxt_st.filt = !st_ff.filt;
						nxt_st.rbuf[1] = {7'h00, !st_ff.filt};
					end
					tuf_pkg::CMD_PWRDN:
					begin
						nxt_st.pwr = !st_ff.pwr;
						nxt_st.rbuf[1] = {7'h00, !st_ff.pwr};
					end
					tuf_pkg::CMD_ECHO:
					begin
						nxt_st.echo = !st_ff.echo;
						nxt_st.rbuf[1] = {7'h00, !st_ff.echo};
					end
					tuf_pkg::CMD_PRESS:
					begin
						nxt_st.press = !st_ff.press;
						nxt_st.rbuf[1] = {7'h00, !st_ff.press};
					end
					tuf_pkg::CMD_CALCHK:
					begin
						nxt_st.calchk = !st_ff.calchk;
						nxt_st.rbuf[1] = {7'h00, !st_ff.calchk};
					end
					tuf_pkg::CMD_WAKE:
					begin
						// Wakeup is never answered; the host must pace itself.
						nxt_st.wake = 1'b1;
						nxt_st.len = 4'h0;
					end
					tuf_pkg::CMD_SHUT:
					begin
						nxt_st.shut = 1'b1;
						nxt_st.len = 4'h1;
					end
					tuf_pkg::CMD_SRESET:
					begin
						nxt_st.sreset = 1'b1;
						nxt_st.rbuf[1] = selftest_ok_i ? tuf_pkg::RPL_TEST_OK
							: tuf_pkg::RPL_TEST_BAD;
					end
					tuf_pkg::CMD_CLKRD:
						nxt_st.rbuf[1] = {7'h00, st_ff.clk_fast};
					tuf_pkg::CMD_PARAMS:
					begin
						nxt_st.rbuf[1] = VER_YEAR;
						nxt_st.rbuf[2] = {5'h00, st_ff.mode};
						nxt_st.rbuf[3] = {7'h00, st_ff.pwr};
						nxt_st.rbuf[4] = {2'h0, st_ff.samples};
						nxt_st.rbuf[5] = {7'h00, st_ff.clk_fast};
						nxt_st.rbuf[6] = VER_MONTH;
						nxt_st.rbuf[7] = VER_DAY;
						nxt_st.rbuf[8] = {2'h0, st_ff.focus};
						nxt_st.rbuf[9] = {2'h0, st_ff.delta};
						nxt_st.rbuf[10] = {4'h0, st_ff.calcnt};
						nxt_st.rbuf[11] = {2'h0, st_ff.calchk, st_ff.press, st_ff.echo,
							st_ff.pwr, 1'b0, st_ff.filt};
						nxt_st.rbuf[12] = {1'b0, st_ff.minp};
						nxt_st.len = tuf_pkg::PARAMS_LEN;
					end
					tuf_pkg::CMD_VERSION:
					begin
						nxt_st.rbuf[0] = tuf_pkg::RPL_VERSION;
						nxt_st.rbuf[1] = VER_YEAR;
						nxt_st.rbuf[2] = VER_MONTH;
						nxt_st.rbuf[3] = VER_DAY;
						nxt_st.len = 4'h4;
					end
					// No point table is held here, so both reads return the count only.
					tuf_pkg::CMD_CALCNT, tuf_pkg::CMD_CALPTS:
						nxt_st.rbuf[1] = {4'h0, st_ff.calcnt};
					tuf_pkg::CMD_FOCUS, tuf_pkg::CMD_SAMPLES, tuf_pkg::CMD_MODE,
					tuf_pkg::CMD_DELTA, tuf_pkg::CMD_CALSET, tuf_pkg::CMD_MINP:
					begin
						nxt_st.pend = b;
						nxt_st.wait_arg = 1'b1;
						nxt_st.len = 4'h0;
					end
					default:
					begin
						nxt_st.rbuf[0] = tuf_pkg::RPL_ERROR;
						nxt_st.len = 4'h1;
					end
				endcase
			end
			else if (st_ff.wait_arg)
			begin
				nxt_st.wait_arg = 1'b0;
				nxt_st.rbuf[1] = b;
				case (st_ff.pend)
					tuf_pkg::CMD_FOCUS:
						nxt_st.focus = b[5:0];
					tuf_pkg::CMD_SAMPLES:
						if ($onehot(b[5:0]))
							nxt_st.samples = b[5:0];
						else
							nxt_st.len = 4'h0;
					tuf_pkg::CMD_MODE:
						if (b == 8'h01 || b == 8'h02 || b == 8'h04)
							nxt_st.mode = b[2:0];
						else
							nxt_st.len = 4'h0;
					tuf_pkg::CMD_DELTA:
						nxt_st.delta = b[5:0];
					tuf_pkg::CMD_CALSET:
					begin
						nxt_st.calsel = b;
						case (b[6:4])
							3'h1: nxt_st.calcnt = 4'h2;
							3'h2: nxt_st.calcnt = 4'h5;
							3'h4: nxt_st.calcnt = 4'hd;
							default: nxt_st.len = 4'h0;
						endcase
					end
					tuf_pkg::CMD_MINP:
						nxt_st.minp = b[6:0];
					default:
						nxt_st.len = 4'h0;
				endcase
				// A refused argument is answered with the error code alone.
				if (nxt_st.len == 4'h0)
				begin
					nxt_st.rbuf[0] = tuf_pkg::RPL_ERROR;
					nxt_st.rbuf[1] = 8'h00;
					nxt_st.len = 4'h1;
				end
			end
			else
				nxt_st.len = 4'h0;
		end
		else if (st_ff.len == 4'h0 && st_ff.ovr)
		begin
			nxt_st.ovr = 1'b0;
			nxt_st.rbuf[0] = tuf_pkg::RPL_ERROR;
			nxt_st.len = 4'h1;
		end
		else if (st_ff.len == 4'h0 && st_ff.to_pend)
		begin
			nxt_st.to_pend = timeout_i;
			nxt_st.rbuf[0] = tuf_pkg::RPL_TIMEOUT;
			nxt_st.len = 4'h1;
		end
		else if (st_ff.len == 4'h0 && st_ff.rs_pend)
		begin
			nxt_st.rs_pend = resend_i;
			nxt_st.rbuf[0] = tuf_pkg::RPL_RESEND;
			nxt_st.len = 4'h1;
		end
		else if (pkt_take)
		begin
			nxt_st.rbuf[0] = {1'b1, 2'b00, st_ff.press, 4'h0};
			nxt_st.rbuf[1] = {1'b0, rpt_touch_i, rpt_x_i[2:0], rpt_y_i[2:0]};
			nxt_st.rbuf[2] = {1'b0, rpt_x_i[9:3]};
			nxt_st.rbuf[3] = {1'b0, rpt_y_i[9:3]};
			nxt_st.rbuf[4] = {1'b0, rpt_z_i};
			nxt_st.len = st_ff.press ? tuf_pkg::PKT_LEN_LONG
				: tuf_pkg::PKT_LEN_SHORT;
		end
		// Receiver: start is rechecked at mid bit, then each bit is sampled mid cell.
		case (st_ff.rx_st)
			RX_IDLE:
				if (!st_ff.rx_lvl)
				begin
					nxt_st.rx_cnt = tuf_pkg::HALF_LAST;
					nxt_st.rx_st = RX_START;
				end
			RX_START:
				if (st_ff.rx_cnt != 11'h000)
					nxt_st.rx_cnt = st_ff.rx_cnt - 11'h001;
				else if (!st_ff.rx_lvl)
				begin
					nxt_st.rx_cnt = tuf_pkg::BIT_LAST;
					nxt_st.rx_bit = 3'h0;
					nxt_st.rx_st = RX_DATA;
				end
				else
					nxt_st.rx_st = RX_IDLE;
			RX_DATA:
				if (st_ff.rx_cnt != 11'h000)
					nxt_st.rx_cnt = st_ff.rx_cnt - 11'h001;
				else
				begin
					nxt_st.rx_sh = {st_ff.rx_lvl, st_ff.rx_sh[7:1]};
					nxt_st.rx_cnt = tuf_pkg::BIT_LAST;
					nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
					if (st_ff.rx_bit == 3'h7)
						nxt_st.rx_st = RX_STOP;
				end
			RX_STOP:
				if (st_ff.rx_cnt != 11'h000)
					nxt_st.rx_cnt = st_ff.rx_cnt - 11'h001;
				else
				begin
					nxt_st.rx_st = RX_IDLE;
					// A low stop bit marks a broken frame and the byte is dropped.
					if (st_ff.rx_lvl)
					begin
						if (nxt_st.have)
							nxt_st.ovr = 1'b1;
						nxt_st.hold = st_ff.rx_sh;
						nxt_st.have = 1'b1;
					end
				end
			default:
				nxt_st.rx_st = RX_IDLE;
		endcase
		// Transmitter: start bit, eight data bits LSB first, one stop bit.
		if (!st_ff.tx_busy)
		begin
			if (pop_s.valid)
			begin
				nxt_st.tx_sh = {1'b1, pop_s.data, 1'b0};
				nxt_st.tx_busy = 1'b1;
				nxt_st.tx_cnt = tuf_pkg::BIT_LAST;
				nxt_st.tx_bit = tuf_pkg::FRAME_BITS - 4'h1;
			end
		end
		else if (st_ff.tx_cnt != 11'h000)
			nxt_st.tx_cnt = st_ff.tx_cnt - 11'h001;
		else
		begin
			nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
			nxt_st.tx_cnt = tuf_pkg::BIT_LAST;
			nxt_st.tx_bit = st_ff.tx_bit - 4'h1;
			if (st_ff.tx_bit == 4'h0)
				nxt_st.tx_busy = 1'b0;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	AST_PKT_LEN: assert property (pkt_take |=> st_ff.len == ($past(st_ff.press) ? 4'h5 : 4'h4))
		else $error("packet length does not follow pressure enable");
	AST_PKT_HDR: assert property (pkt_take |=> st_ff.rbuf[0] == {3'b100, $past(st_ff.press), 4'h0})
		else $error("packet header byte malformed");
	AST_PKT_STATE: assert property (pkt_take |=> st_ff.rbuf[1][7:6] == {1'b0, $past(rpt_touch_i)})
		else $error("touch state bit wrong");
	AST_PKT_XY: assert property (pkt_take |=> st_ff.rbuf[2] == {1'b0, $past(rpt_x_i[9:3])}
		&& st_ff.rbuf[3] == {1'b0, $past(rpt_y_i[9:3])})
		else $error("coordinate high bits misplaced");
	AST_CLK_READ: assert property (take && b == tuf_pkg::CMD_CLKRD |=> st_ff.len == 4'h2
		&& st_ff.rbuf[0] == tuf_pkg::RPL_ACK && st_ff.rbuf[1][0] == $past(st_ff.clk_fast))
		else $error("clock speed reply wrong");
	AST_VERSION: assert property (take && b == tuf_pkg::CMD_VERSION |=>
		st_ff.rbuf[0] == tuf_pkg::RPL_VERSION && st_ff.len == 4'h4)
		else $error("version read not answered with version code");
	AST_TOGGLE: assert property (take && b == tuf_pkg::CMD_PRESS |=>
		st_ff.press != $past(st_ff.press) && st_ff.rbuf[1] == {7'h00, st_ff.press})
		else $error("pressure toggle failed");
	AST_MINP: assert property (take && !b[7] && st_ff.wait_arg && st_ff.pend == tuf_pkg::CMD_MINP
		|=> min_press_o == {$past(b[6:0]), 1'b0} && st_ff.rbuf[1] == $past(b))
		else $error("minimum pressure not stored doubled");
	AST_TX_FRAME: assert property ($rose(st_ff.tx_busy) |-> !uart_tx_o [*8])
		else $error("start bit shorter than expected");
endmodule // tuf_framer
`default_nettype wire

// file: verification/tuf_host_model.sv
// Host-side serial model: sends command frames and receives reply frames.
`timescale 1ns/1ps
`default_nettype none
module tuf_host_model (
	input wire logic clk_i,
	input wire logic line_from_dev_i,
	output logic line_to_dev_o
);
	// The host line idles high between frames.
	initial line_to_dev_o = 1'b1;

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Start bit, eight data bits LSB first, then one stop bit.
	// Returns a quarter bit into the stop bit because the reply may start right after it is sampled.
	// Back-to-back calls end the stop bit a quarter bit in, before the device samples it, so a caller must wait between bytes.
	// Wakeup is never answered, so a caller must wait on its own before the next command.
	task automatic send_byte(input logic [7:0] b);
		logic [8:0] frame;
		frame = {b, 1'b0};
		for (int i = 0; i < 9; i++)
		begin
			line_to_dev_o = frame[i];
			wait_cyc(tuf_pkg::BIT_CYC);
		end
		line_to_dev_o = 1'b1;
		wait_cyc(tuf_pkg::BIT_CYC / 4);
	endtask

	// Waits a bounded time for a start bit and samples each bit in mid cell.
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		ok = 1'b0;
		while (line_from_dev_i !== 1'b0 && n < 20 * tuf_pkg::BIT_CYC)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 20 * tuf_pkg::BIT_CYC)
			return;
		wait_cyc(tuf_pkg::BIT_CYC / 2);
		if (line_from_dev_i !== 1'b0)
			return;
		for (int i = 0; i < 8; i++)
		begin
			wait_cyc(tuf_pkg::BIT_CYC);
			b[i] = line_from_dev_i;
		end
		wait_cyc(tuf_pkg::BIT_CYC);
		ok = (line_from_dev_i === 1'b1);
	endtask
endmodule // tuf_host_model
`default_nettype wire

// file: verification/tuf_framer_tb.sv
// Testbench for the serial command interpreter and packet framer.
`timescale 1ns/1ps
`default_nettype none
module tuf_framer_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic rx_line;
	logic tx_line;
	logic rpt_valid_i = 1'b0;
	logic rpt_ready;
	logic rpt_touch_i = 1'b0;
	logic [9:0] rpt_x_i = 10'h000;
	logic [9:0] rpt_y_i = 10'h000;
	logic [6:0] rpt_z_i = 7'h00;
	logic [5:0] focus;
	logic [5:0] samples;
	logic [2:0] mode;
	logic [5:0] max_delta;
	logic [7:0] min_press;
	logic press_en;
	int failures = 0;
	int comparisons = 0;

	always #10 clk_i = ~clk_i;

	tuf_framer u_tuf_framer (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.uart_rx_i(rx_line),
		.uart_tx_o(tx_line),
		.clk_fast_i(1'b1),
		.selftest_ok_i(1'b1),
		.timeout_i(1'b0),
		.resend_i(1'b0),
		.rpt_valid_i(rpt_valid_i),
		.rpt_ready_o(rpt_ready),
		.rpt_touch_i(rpt_touch_i),
		.rpt_x_i(rpt_x_i),
		.rpt_y_i(rpt_y_i),
		.rpt_z_i(rpt_z_i),
		.focus_o(focus),
		.samples_o(samples),
		.mode_o(mode),
		.max_delta_o(max_delta),
		.min_press_o(min_press),
		.cal_count_o(),
		.filter_en_o(),
		.pwrdn_en_o(),
		.echo_en_o(),
		.press_en_o(press_en),
		.calchk_en_o(),
		.wake_o(),
		.shutdown_o(),
		.soft_reset_o()
	);

	tuf_host_model u_tuf_host_model (
		.clk_i(clk_i),
		.line_from_dev_i(tx_line),
		.line_to_dev_o(rx_line)
	);

	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Configuration outputs and the idle transmit pin straight after reset.
	task automatic check_defaults();
		check8("min_press", {tuf_pkg::DEF_MINP, 1'b0}, min_press);
		check8("focus", {2'b00, tuf_pkg::DEF_FOCUS}, focus);
		check8("samples", {2'b00, tuf_pkg::DEF_SAMPLES}, samples);
		check8("mode", {5'h00, tuf_pkg::DEF_MODE}, mode);
		check8("max_delta", {2'b00, tuf_pkg::DEF_DELTA}, max_delta);
		check8("press_en", 8'h00, {7'h00, press_en});
		check8("tx_idle", 8'h01, {7'h00, tx_line});
	endtask

	// Turns pressure on, then offers a report while the toggle reply is still
	// going out, so the packet must wait for the reply and come out long.
	task automatic toggle_and_packet();
		logic [7:0] b;
		logic ok;
		logic [7:0] exp_pkt [5];
		int n;
		u_tuf_host_model.send_byte(tuf_pkg::CMD_PRESS);
		u_tuf_host_model.recv_byte(b, ok);
		check8("ack", tuf_pkg::RPL_ACK, b);
		check8("ack_stop", 8'h01, {7'h00, ok});
		fork
			begin
				rpt_touch_i = 1'b1;
				rpt_x_i = 10'h2b5;
				rpt_y_i = 10'h14a;
				rpt_z_i = 7'h5c;
				rpt_valid_i = 1'b1;
				n = 0;
				while (rpt_ready !== 1'b1 && n < 40 * tuf_pkg::BIT_CYC)
				begin
					@(posedge clk_i);
					#1;
					n++;
				end
				@(posedge clk_i);
				#1;
				rpt_valid_i = 1'b0;
			end
			begin
				u_tuf_host_model.recv_byte(b, ok);
				check8("toggle_state", 8'h01, b);
				check8("press_en", 8'h01, {7'h00, press_en});
			end
		join
		exp_pkt = '{{1'b1, 2'b00, 1'b1, 4'h0}, {2'b01, rpt_x_i[2:0], rpt_y_i[2:0]},
			{1'b0, rpt_x_i[9:3]}, {1'b0, rpt_y_i[9:3]}, {1'b0, rpt_z_i}};
		for (int i = 0; i < 5; i++)
		begin
			u_tuf_host_model.recv_byte(b, ok);
			check8("packet", exp_pkt[i], b);
			check8("packet_stop", 8'h01, {7'h00, ok});
		end
	endtask

	// The two scenarios need about eight frames of 13020 cycles each.
	initial
	begin
		repeat (110000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end

	initial
	begin
		repeat (10) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		check_defaults();
		toggle_and_packet();
		report_and_stop();
	end
endmodule // tuf_framer_tb
`default_nettype wire
